// ===== design/ousc_defines.vh
// Contract
// - requests arrive as framing byte, address byte, then command byte; command selects function.
// - accepted reset reloads synthesizer divider, clears status and alarms, keeps password tally.
// - rejections are single codes: unsupported, parity error, unknown format.
// - reset while locked is refused with the locked rejection reply.
// - accepted reset answers acknowledge, then performs full software reset.
// - only power cycling clears the lock; software reset leaves it.
// - status request answers acknowledge plus alarm, state and reserved bytes.
// - status request is answered even while locked, never with locked code.
// - alarm flags stay set until status read or accepted reset.
// - in download mode only download alarms and main state are meaningful.
// - alarm bits 7,6,5 flag self-test, synthesizer unlock, power supply fault.
// - alarm bits 4..2 carry wrong-password tally, bit 4 msb, zero to six.
// - alarm bit 1 flags image checksum failure, bit 0 other download error.
// - state bits 7..4 and 1 zero; bit 3 amplifier, 2 running, 0 download.
// - third status byte is reserved and reads all zero.
// - identification request after power-up or reset moves unit on-line.
// - manufacturer identification answers acknowledge plus first three identifier bytes.
// - product identification answers acknowledge plus remaining five identifier bytes.
// - six or more wrong passwords make identification requests answer locked reply.
// - six consecutive wrong passwords lock unit, disable amplifier, power down transmitter.
// - while locked refuse all but status, transmitter disable and download commands.
`ifndef OUSC_DEFINES_VH
`define OUSC_DEFINES_VH
`define OUSC_FRAME_CMD     8'hE2
`define OUSC_ADDR_UNIT     8'h82
`define OUSC_CMD_RESET     8'h0A
`define OUSC_CMD_STATUS    8'h12
`define OUSC_CMD_MANUF_ID  8'h5C
`define OUSC_CMD_PROD_ID   8'h5D
`define OUSC_CMD_TX_OFF    8'hC7
`define OUSC_CMD_DL_LO     8'hC0
`define OUSC_CMD_DL_HI     8'hC5
`define OUSC_RPL_ACK       8'hE4
`define OUSC_RPL_UNSUP     8'hE5
`define OUSC_RPL_PARITY    8'hE6
`define OUSC_RPL_FORMAT    8'hE7
`define OUSC_RPL_LOCKED    8'hED
`define OUSC_RPL_LOCKED2   8'hFF
`define OUSC_BIT_SELFTEST  7
`define OUSC_BIT_PLL       6
`define OUSC_BIT_PSU       5
`define OUSC_BIT_TALLY_HI  4
`define OUSC_BIT_TALLY_LO  2
`define OUSC_BIT_DL_CRC    1
`define OUSC_BIT_DL_OTHER  0
`define OUSC_BIT_AMP       3
`define OUSC_BIT_RUN       2
`define OUSC_BIT_DL_STATE  0
`define OUSC_TALLY_LOCK    3'h6
`define OUSC_RESET_PULSE   8'h04
`define OUSC_EUI_DEFAULT   64'h0123456789ABCDEF
`endif

// ===== design/ousc_cmd_handler.v
`include "ousc_defines.vh"
module ousc_cmd_handler #(
    // identifier value is arbitrary
    parameter [63:0] EUI_VALUE = `OUSC_EUI_DEFAULT
) (
    // clock and reset
    input  wire       clk,
    input  wire       sys_rst,
    // received bytes from the link receiver
    input  wire       rxValid,
    input  wire [7:0] rxByte,
    input  wire       rxParityErr,
    input  wire       rxEnd,
    // reply byte stream to the link transmitter
    output wire       txValid,
    input  wire       txReady,
    output reg  [7:0] txByte,
    output wire       txLast,
    // fault and state inputs
    input  wire       faultSelfTest,
    input  wire       faultPllUnlock,
    input  wire       faultPsu,
    input  wire       dlCrcErr,
    input  wire       dlOtherErr,
    input  wire       ampOn,
    input  wire       runState,
    input  wire       dlState,
    input  wire       wrongPwd,
    input  wire       goodPwd,
    // actions toward the unit
    output reg        synthReload,
    output reg        softReset,
    output reg        onLine,
    output reg        ampDisable,
    output reg        txPowerDown,
    output reg        locked
);

localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_ADDR = 5'h02;
localparam [4:0] ST_CMD  = 5'h04;
localparam [4:0] ST_WAIT = 5'h08;
localparam [4:0] ST_SEND = 5'h10;

reg [4:0]  state_q;
reg [7:0]  cmd_q;
reg        parErr_q;
reg        fmtErr_q;
reg [3:0]  len_q;
reg [3:0]  idx_q;
reg [63:0] rply_q;
reg        doReset_q;
reg [2:0]  tally_q;
reg [7:0]  rstCnt_q;
// frame state including the byte on the link this cycle
reg        parNow;
reg        fmtNow;
reg [7:0]  cmdNow;

////////////////////////////////////////////////////////////////////////////
// frame end and reply acceptance
// rxEnd may ride on the last byte, so the end is taken in every receive state;
// waiting for a later rxEnd would hang a frame that closes on its last byte
wire frameDone = rxEnd && (((state_q == ST_IDLE) && rxValid) ||
                           (state_q == ST_ADDR) ||
                           (state_q == ST_CMD) ||
                           (state_q == ST_WAIT));
// the last reply byte of an accepted reset is taken
wire resetAccept = doReset_q && (state_q == ST_SEND) && txLast && txReady;

////////////////////////////////////////////////////////////////////////////
// status bytes
wire [7:0] alarmByte;
wire [7:0] stateByte;
wire       statusRead;
// alarm inputs in byte order, self-test first
wire [4:0] faultIn    = {faultSelfTest, faultPllUnlock, faultPsu, dlCrcErr, dlOtherErr};
wire [4:0] alarmBits;
wire       alarmClear = statusRead || resetAccept;

// in download mode the other fields are still driven but carry no meaning
assign stateByte = {4'h0, ampOn, runState, 1'b0, dlState};
assign alarmByte = {alarmBits[4:2], tally_q, alarmBits[1:0]};

// each flag sets and holds; a fault present in the clearing cycle wins,
// so a fault that persists across a status read is reported again
genvar gi;
generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_alarm
        reg hold_q;
        always @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                hold_q <= 1'b0;
            end else begin
                hold_q <= (hold_q & ~alarmClear) | faultIn[gi];
            end
        end
        assign alarmBits[gi] = hold_q;
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// wrong-password tally and lock; lock clears only at power-up reset
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        tally_q     <= 3'h0;
        locked      <= 1'b0;
        ampDisable  <= 1'b0;
        txPowerDown <= 1'b0;
    end else begin
        if (wrongPwd && tally_q < `OUSC_TALLY_LOCK) begin
            tally_q <= tally_q + 3'h1;
        end else if (goodPwd && !locked) begin
            tally_q <= 3'h0;
        end
        if (wrongPwd && tally_q == `OUSC_TALLY_LOCK - 3'h1) begin
            locked      <= 1'b1;
            ampDisable  <= 1'b1;
            txPowerDown <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// request decode and reply selection
// errors and command folded with the current byte, so a frame that ends on
// this byte is judged on all of it
always @* begin
    parNow = parErr_q;
    fmtNow = fmtErr_q;
    cmdNow = cmd_q;
    case (state_q)
        ST_IDLE: begin
            parNow = rxParityErr;
            // a frame that ends on its first byte is too short
            fmtNow = (rxByte != `OUSC_FRAME_CMD) || rxEnd;
        end
        ST_ADDR: begin
            if (rxValid) begin
                parNow = parErr_q | rxParityErr;
                fmtNow = fmtErr_q | (rxByte != `OUSC_ADDR_UNIT) | rxEnd;
            end else begin
                fmtNow = fmtErr_q | rxEnd;
            end
        end
        ST_CMD: begin
            if (rxValid) begin
                parNow = parErr_q | rxParityErr;
                cmdNow = rxByte;
            end else begin
                fmtNow = fmtErr_q | rxEnd;
            end
        end
        ST_WAIT: begin
            // bytes past the command make an unknown format
            if (rxValid) begin
                parNow = parErr_q | rxParityErr;
                fmtNow = 1'b1;
            end
        end
        default: begin
            parNow = parErr_q;
        end
    endcase
end

wire isDlCmd = (cmdNow >= `OUSC_CMD_DL_LO) && (cmdNow <= `OUSC_CMD_DL_HI);
wire lockExempt = (cmdNow == `OUSC_CMD_STATUS) || (cmdNow == `OUSC_CMD_TX_OFF) || isDlCmd;
wire lockedNow = locked || (tally_q >= `OUSC_TALLY_LOCK);

reg [63:0] selData;
reg [3:0]  selLen;
reg        selReset;
reg        selStatus;
always @* begin
    selData   = 64'h0;
    selLen    = 4'h1;
    selReset  = 1'b0;
    selStatus = 1'b0;
    // fixed priority: parity, format, lock, function
    if (parNow) begin
        selData[63:56] = `OUSC_RPL_PARITY;
    end else if (fmtNow) begin
        selData[63:56] = `OUSC_RPL_FORMAT;
    end else if (lockedNow && !lockExempt) begin
        selData[63:48] = {`OUSC_RPL_LOCKED, `OUSC_RPL_LOCKED2};
        selLen         = 4'h2;
    end else begin
        case (cmdNow)
            `OUSC_CMD_RESET: begin
                selData[63:56] = `OUSC_RPL_ACK;
                selReset       = 1'b1;
            end
            `OUSC_CMD_STATUS: begin
                selData[63:32] = {`OUSC_RPL_ACK, alarmByte, stateByte, 8'h00};
                selLen         = 4'h4;
                selStatus      = 1'b1;
            end
            `OUSC_CMD_MANUF_ID: begin
                selData[63:32] = {`OUSC_RPL_ACK, EUI_VALUE[63:40]};
                selLen         = 4'h4;
            end
            `OUSC_CMD_PROD_ID: begin
                selData[63:16] = {`OUSC_RPL_ACK, EUI_VALUE[39:0]};
                selLen         = 4'h6;
            end
            default: begin
                selData[63:56] = `OUSC_RPL_UNSUP;
            end
        endcase
    end
end

assign statusRead = frameDone && selStatus;
assign txValid = (state_q == ST_SEND);
assign txLast  = (state_q == ST_SEND) && (idx_q == len_q - 4'h1);

always @* begin
    txByte = rply_q[63:56];
end

////////////////////////////////////////////////////////////////////////////
// frame receiver and reply sequencer
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        state_q   <= ST_IDLE;
        cmd_q     <= 8'h00;
        parErr_q  <= 1'b0;
        fmtErr_q  <= 1'b0;
        len_q     <= 4'h1;
        idx_q     <= 4'h0;
        rply_q    <= 64'h0;
        doReset_q <= 1'b0;
        onLine    <= 1'b0;
    end else begin
        case (state_q)
            ST_IDLE: begin
                parErr_q <= 1'b0;
                fmtErr_q <= 1'b0;
                if (rxValid) begin
                    parErr_q <= parNow;
                    fmtErr_q <= fmtNow;
                    state_q  <= ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (rxValid) begin
                    parErr_q <= parNow;
                    fmtErr_q <= fmtNow;
                    state_q  <= ST_CMD;
                end
            end
            ST_CMD: begin
                if (rxValid) begin
                    parErr_q <= parNow;
                    cmd_q    <= cmdNow;
                    state_q  <= ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (rxValid) begin
                    parErr_q <= parNow;
                    fmtErr_q <= fmtNow;
                end
            end
            ST_SEND: begin
                if (txReady) begin
                    rply_q <= {rply_q[55:0], 8'h00};
                    idx_q  <= idx_q + 4'h1;
                    if (txLast) begin
                        state_q   <= ST_IDLE;
                        doReset_q <= 1'b0;
                        if (doReset_q) begin
                            onLine <= 1'b0;
                        end
                    end
                end
            end
            default: begin
                state_q <= ST_IDLE;
            end
        endcase
        // the frame end overrides the receive step above
        if (frameDone) begin
            rply_q    <= selData;
            len_q     <= selLen;
            doReset_q <= selReset;
            idx_q     <= 4'h0;
            state_q   <= ST_SEND;
            if (!parNow && !fmtNow && !lockedNow &&
                (cmdNow == `OUSC_CMD_MANUF_ID || cmdNow == `OUSC_CMD_PROD_ID)) begin
                onLine <= 1'b1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// software reset pulse after the acknowledge leaves; the tally is untouched
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        rstCnt_q    <= 8'h00;
        softReset   <= 1'b0;
        synthReload <= 1'b0;
    end else begin
        if (resetAccept) begin
            rstCnt_q <= `OUSC_RESET_PULSE;
        end else if (rstCnt_q != 8'h00) begin
            rstCnt_q <= rstCnt_q - 8'h01;
        end
        softReset   <= (rstCnt_q != 8'h00);
        synthReload <= (rstCnt_q == `OUSC_RESET_PULSE);
    end
end

endmodule // ousc_cmd_handler

// ===== sim/ousc_cmd_handler_sva.sv
`include "ousc_defines.vh"
module ousc_cmd_handler_sva (
    // clock and reset
    input wire       clk,
    input wire       sys_rst,
    // watched ports
    input wire       rxEnd,
    input wire       txValid,
    input wire       txReady,
    input wire [7:0] txByte,
    input wire       txLast,
    input wire       wrongPwd,
    input wire       synthReload,
    input wire       softReset,
    input wire       ampDisable,
    input wire       txPowerDown,
    input wire       locked
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    //////////////////////////////////////////////////////////////////////////
    a_reply_starts: assert property (rxEnd && !txValid |=> txValid)
        else $error("no reply after request end");
    a_byte_holds: assert property (txValid && !txReady |=> txValid && $stable(txByte))
        else $error("reply byte changed while stalled");
    a_locked_pair: assert property (txValid && txReady && !txLast && txByte == `OUSC_RPL_LOCKED
        |=> txValid && txLast && txByte == `OUSC_RPL_LOCKED2) else $error("bad locked reply");
    a_reset_pulse: assert property ($rose(softReset) |-> softReset[*4] ##1 !softReset)
        else $error("soft reset length wrong");
    a_reload_rst: assert property (synthReload |-> softReset)
        else $error("reload outside soft reset");
    a_lock_sticky: assert property (locked |=> locked) else $error("lock dropped");
    a_lock_actions: assert property (locked |-> ampDisable && txPowerDown)
        else $error("locked without amplifier shutdown");
    a_lock_cause: assert property ($rose(locked) |-> $past(wrongPwd) || $past(wrongPwd, 2))
        else $error("lock without wrong password");
    c_reply_done: cover property (txValid && txReady && txLast);
    c_soft_reset: cover property ($rose(softReset));
    c_lock: cover property ($rose(locked));
endmodule // ousc_cmd_handler_sva
bind ousc_cmd_handler ousc_cmd_handler_sva ousc_cmd_handler_sva_i (.*);

// ===== sim/ousc_idu_model.sv
module ousc_idu_model (
    // link toward the outdoor unit
    input  wire        clk,
    input  wire        slow,
    output logic       rxValid,
    output logic [7:0] rxByte,
    output logic       rxParityErr,
    output logic       rxEnd,
    // reply side
    input  wire        txValid,
    input  wire  [7:0] txByte,
    input  wire        txLast,
    output logic       txReady
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rsp[$];
    initial begin
        rxValid = 1'b0;
        rxByte = 8'h00;
        rxParityErr = 1'b0;
        rxEnd = 1'b0;
        txReady = 1'b0;
    end
    // a slow master drops txReady every other cycle, so each reply byte after an accepted one waits a cycle
    always @(posedge clk) txReady <= slow ? ~txReady : 1'b1;
    task automatic req(input logic [23:0] m, input int n, input bit par);
        rsp.delete();
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            rxValid <= 1'b1;
            rxByte <= m[23 - 8*k -: 8];
            rxParityErr <= par;
            rxEnd <= (k == n - 1);
        end
        @(posedge clk);
        rxValid <= 1'b0;
        rxEnd <= 1'b0;
        rxParityErr <= 1'b0;
        // bounded wait: a missing reply shows up as a short response
        // look at the falling edge, where the handshake of the next rising edge is settled
        for (int k = 0; k < 60; k++) begin
            @(negedge clk);
            if (txValid === 1'b1 && txReady === 1'b1) begin
                rsp.push_back(txByte);
                if (txLast === 1'b1) break;
            end
        end
        @(posedge clk);
    endtask
endmodule // ousc_idu_model

// ===== sim/ousc_cmd_handler_tb_top.sv
module ousc_cmd_handler_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, sys_rst = 1'b1, slow = 1'b0, wrongPwd = 1'b0, goodPwd = 1'b0;
    logic [4:0] fault = 5'h00;
    logic [2:0] st = 3'h0;
    logic       rxValid, rxParityErr, rxEnd, txValid, txReady, txLast;
    logic       synthReload, softReset, onLine, ampDisable, txPowerDown, locked;
    logic [7:0] rxByte, txByte;
    int         errors = 0, cmp_count = 0;
    ousc_idu_model ousc_idu_model_i (.clk(clk), .slow(slow), .rxValid(rxValid), .rxByte(rxByte),
        .rxParityErr(rxParityErr), .rxEnd(rxEnd), .txValid(txValid), .txByte(txByte),
        .txLast(txLast), .txReady(txReady));
    ousc_cmd_handler ousc_cmd_handler_i (.clk(clk), .sys_rst(sys_rst), .rxValid(rxValid),
        .rxByte(rxByte), .rxParityErr(rxParityErr), .rxEnd(rxEnd), .txValid(txValid),
        .txReady(txReady), .txByte(txByte), .txLast(txLast), .faultSelfTest(fault[4]),
        .faultPllUnlock(fault[3]), .faultPsu(fault[2]), .dlCrcErr(fault[1]),
        .dlOtherErr(fault[0]), .ampOn(st[2]), .runState(st[1]), .dlState(st[0]),
        .wrongPwd(wrongPwd), .goodPwd(goodPwd), .synthReload(synthReload),
        .softReset(softReset), .onLine(onLine), .ampDisable(ampDisable),
        .txPowerDown(txPowerDown), .locked(locked));
    initial forever #12.5 clk = ~clk;
    //////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic run(input string nm, input logic [23:0] m, input int n, input bit par,
                       input logic [63:0] e, input int len);
        ousc_idu_model_i.req(m, n, par);
        check({nm, " length"}, 8'(ousc_idu_model_i.rsp.size()), 8'(len));
        for (int k = 0; k < len; k++) check(nm, ousc_idu_model_i.rsp[k], e[8*(len-1-k) +: 8]);
    endtask
    task automatic pulse(input int n, input bit good);
        repeat (n) begin
            @(posedge clk);
            wrongPwd <= !good;
            goodPwd <= good;
            @(posedge clk);
            wrongPwd <= 1'b0;
            goodPwd <= 1'b0;
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        errors++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk); // boot wait shortened
        run("manuf id", 24'hE2825C, 3, 0, 64'hE4012345, 4);
        run("prod id", 24'hE2825D, 3, 0, 64'hE46789ABCDEF, 6);
        check("onLine", {7'h00, onLine}, 8'h01);
        $display("test ident done");
        st <= 3'h7;
        fault <= 5'h1F;
        @(posedge clk);
        fault <= 5'h00;
        repeat (2) @(posedge clk);
        run("status", 24'hE28212, 3, 0, 64'hE4E30D00, 4);
        st <= 3'h0;
        run("status again", 24'hE28212, 3, 0, 64'hE4000000, 4);
        $display("test status done");
        slow <= 1'b1;
        run("unsupported", 24'hE28233, 3, 0, 64'hE5, 1);
        run("bad address", 24'hE28312, 3, 0, 64'hE7, 1);
        run("short frame", 24'hE28212, 2, 0, 64'hE7, 1);
        run("parity", 24'hE28233, 3, 1, 64'hE6, 1);
        $display("test reject done");
        pulse(1, 0);
        pulse(1, 1);
        pulse(2, 0);
        fault <= 5'h10;
        @(posedge clk);
        fault <= 5'h00;
        run("reset", 24'hE2820A, 3, 0, 64'hE4, 1); // amplifier off here
        repeat (8) @(posedge clk); // shortened post-reset wait
        check("onLine after reset", {7'h00, onLine}, 8'h00);
        run("status tally", 24'hE28212, 3, 0, 64'hE4080000, 4);
        $display("test reset done");
        pulse(4, 0);
        repeat (2) @(posedge clk);
        check("lock outputs", {5'h00, locked, ampDisable, txPowerDown}, 8'h07);
        run("locked status", 24'hE28212, 3, 0, 64'hE4180000, 4);
        run("locked reset", 24'hE2820A, 3, 0, 64'hEDFF, 2);
        run("locked id", 24'hE2825C, 3, 0, 64'hEDFF, 2);
        run("locked other", 24'hE28233, 3, 0, 64'hEDFF, 2);
        run("locked parity", 24'hE2820A, 3, 1, 64'hE6, 1);
        check("still locked", {7'h00, locked}, 8'h01);
        $display("test lock done");
        final_report();
    end
endmodule // ousc_cmd_handler_tb_top
